// ===== eth_setup_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef ETH_SETUP_REGS_SVH
`define ETH_SETUP_REGS_SVH

// register offsets (byte addresses, one aligned word each)
`define OFS_MODE_CTRL 8'h00
`define OFS_SOFT_RESET 8'h04
`define OFS_KRST_REQ 8'h08
`define OFS_KRST_CLR 8'h0C
`define OFS_DMA_DEBUG 8'h10
`define OFS_RXQ_DEBUG 8'h14
`define OFS_TXQ_DEBUG 8'h18
`define OFS_SETUP_STATUS 8'h1C
`define OFS_ADDR_HIGH 8'h20
`define OFS_ADDR_LOW 8'h24

// field positions
`define BIT_MODE_SEL 0
`define BIT_SOFT_RESET 0
`define BIT_KRST_REQ 0
`define BIT_RST_STATUS 1
`define BIT_STATUS_CLEAR 0
`define BIT_FILL_SETTLED 0
`define BIT_DMA_HALTED 1
`define BIT_ADDR_BUSY 2
`define BIT_LAST_SEGMENT 28
`define FILL_STATE_LSB 4
`define FILL_STATE_MSB 5

// reset values
`define RST_MODE_SEL 1'h0
`define RST_ADDR_HIGH 16'hFFFF
`define RST_ADDR_LOW 32'hFFFFFFFF

// timing: clock period in ps, settle and reset durations
`define CLK_PERIOD_PS 4000
`define FILL_SETTLE_CYCLES 70
`define SOFT_RESET_CYCLES 3
`define KERNEL_RESET_CYCLES 3

`endif

// ===== eth_setup_pkg.sv
// types shared by the reset and address setup logic
package eth_setup_pkg;

    // reset sequencer states
    typedef enum logic [1:0] {
        RST_IDLE = 2'h0,
        RST_SOFT = 2'h1,
        RST_KERNEL = 2'h2
    } reset_state_t;

    // interface mode select encodings
    typedef enum logic {
        MODE_MII = 1'h0,
        MODE_RMII = 1'h1
    } iface_mode_t;

endpackage : eth_setup_pkg

// ===== addr_sync_if.sv
// carrier between the setup controller and the station address transfer unit
`timescale 1ns/1ps
`default_nettype none

interface addr_sync_if;
    logic load;
    logic clear;
    logic [15:0] high_word;
    logic [31:0] low_word;
    logic [47:0] station_address;
    logic busy;

    modport ctrl (output load, output clear, output high_word, output low_word,
                  input station_address, input busy);
    modport unit (input load, input clear, input high_word, input low_word,
                  output station_address, output busy);
endinterface : addr_sync_if

`default_nettype wire

// ===== station_addr_sync.sv
// two-stage transfer of the station address into the receive filter side
`timescale 1ns/1ps
`default_nettype none
`include "eth_setup_regs.svh"

module station_addr_sync (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // controller side
    addr_sync_if.unit sync
);

    logic [1:0] stage;
    logic [47:0] captured;

    // capture both words on the trigger, then walk two stages before use
    always_ff @(posedge clk) begin
        if (srst || sync.clear) begin
            stage <= 2'h0;
            captured <= {`RST_ADDR_HIGH, `RST_ADDR_LOW};
        end else begin
            if (sync.load) begin
                captured <= {sync.high_word, sync.low_word};
            end
            stage <= {stage[0], sync.load};
        end
    end

    // filter address changes only after the second stage, never half-written
    always_ff @(posedge clk) begin
        if (srst || sync.clear) begin
            sync.station_address <= {`RST_ADDR_HIGH, `RST_ADDR_LOW};
        end else if (stage[1]) begin
            sync.station_address <= captured;
        end
    end

    assign sync.busy = |stage;

endmodule : station_addr_sync

`default_nettype wire

// ===== eth_reset_setup.sv
// reset preparation, soft and kernel reset, descriptor check, station address setup
//
// Overview of operation
// - queue fill state needs 70 cycles after reset before a reading is final.
// - kernel reset request and clear registers take writes only supervisor, unlocked.
// - kernel request write resets and sets status flag; clear bit write clears it.
// - soft reset bit starts module reset and clears itself within four cycles.
// - last-segment descriptor with a zero buffer length halts transmit and receive DMA.
// - station address moves through two stages, triggered by the low word write.
// - a wrong station address transfer would misfilter and lose received packets.
`timescale 1ns/1ps
`default_nettype none
`include "eth_setup_regs.svh"

module eth_reset_setup (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // access privilege of the current write
    input wire logic supervisor_mode,
    input wire logic init_lock_active,
    // state reported by the DMA and queue logic
    input wire logic [3:0] rx_process_state,
    input wire logic [3:0] tx_process_state,
    input wire logic [31:0] rx_queue_debug,
    input wire logic [31:0] tx_queue_debug,
    // transmit descriptors as fetched by the DMA
    input wire logic desc_valid,
    input wire logic [31:0] tx_descriptor_word2,
    input wire logic [31:0] tx_descriptor_word3,
    // controls to the rest of the MAC
    output logic module_reset,
    output logic interface_mode_select,
    output logic dma_halted,
    output logic [47:0] station_address
);

    localparam int SETTLE_W = $clog2(`FILL_SETTLE_CYCLES + 1);

    eth_setup_pkg::reset_state_t state;
    eth_setup_pkg::reset_state_t next_state;
    logic [1:0] rst_count;
    logic soft_reset_request;
    logic reset_status_flag;
    logic [15:0] addr_high;
    logic [31:0] addr_low;
    logic [SETTLE_W-1:0] settle_count;
    logic fill_settled;
    logic privileged;
    logic wr_mode;
    logic wr_soft;
    logic wr_krst;
    logic wr_kclr;
    logic wr_high;
    logic wr_low;
    logic desc_bad;
    logic internal_clear;
    logic [31:0] rx_debug_view;
    logic [31:0] next_rdata;

    addr_sync_if sync ();

    // write decode; privileged registers ignore anything else silently
    assign privileged = supervisor_mode && !init_lock_active;
    assign wr_mode = reg_write && (reg_addr == `OFS_MODE_CTRL);
    assign wr_soft = reg_write && (reg_addr == `OFS_SOFT_RESET)
                     && reg_wdata[`BIT_SOFT_RESET];
    assign wr_krst = reg_write && (reg_addr == `OFS_KRST_REQ) && privileged
                     && reg_wdata[`BIT_KRST_REQ];
    assign wr_kclr = reg_write && (reg_addr == `OFS_KRST_CLR) && privileged
                     && reg_wdata[`BIT_STATUS_CLEAR];
    assign wr_high = reg_write && (reg_addr == `OFS_ADDR_HIGH);
    assign wr_low = reg_write && (reg_addr == `OFS_ADDR_LOW);

    // zero length on either buffer with last segment set is fatal to the DMA
    assign desc_bad = desc_valid && tx_descriptor_word3[`BIT_LAST_SEGMENT]
                      && ((tx_descriptor_word2[13:0] == 14'h0000)
                          || (tx_descriptor_word2[29:16] == 14'h0000));

    // internal state is cleared while the sequencer holds the module in reset
    assign internal_clear = (state != eth_setup_pkg::RST_IDLE);

    // reset sequencer: kernel reset takes priority over a soft reset
    always_comb begin
        next_state = state;
        unique case (state)
            eth_setup_pkg::RST_IDLE: begin
                if (wr_krst) begin
                    next_state = eth_setup_pkg::RST_KERNEL;
                end else if (wr_soft) begin
                    next_state = eth_setup_pkg::RST_SOFT;
                end
            end
            eth_setup_pkg::RST_SOFT: begin
                if (rst_count == 2'h0) begin
                    next_state = eth_setup_pkg::RST_IDLE;
                end
            end
            eth_setup_pkg::RST_KERNEL: begin
                if (rst_count == 2'h0) begin
                    next_state = eth_setup_pkg::RST_IDLE;
                end
            end
            default: next_state = eth_setup_pkg::RST_IDLE;
        endcase
    end

    // sequencer state and its duration count
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= eth_setup_pkg::RST_IDLE;
            rst_count <= 2'h0;
        end else begin
            state <= next_state;
            if (state == eth_setup_pkg::RST_IDLE) begin
                rst_count <= wr_krst ? 2'(`KERNEL_RESET_CYCLES - 1)
                                     : 2'(`SOFT_RESET_CYCLES - 1);
            end else if (rst_count != 2'h0) begin
                rst_count <= rst_count - 2'h1;
            end
        end
    end

    // soft reset bit reads one until the reset has run, then clears itself
    always_ff @(posedge clk) begin
        if (srst) begin
            soft_reset_request <= 1'h0;
        end else if (state == eth_setup_pkg::RST_IDLE) begin
            soft_reset_request <= wr_soft && !wr_krst;
        end else if (next_state == eth_setup_pkg::RST_IDLE) begin
            soft_reset_request <= 1'h0;
        end
    end

    // module reset pulse train to DMA, queues and MAC
    always_ff @(posedge clk) begin
        if (srst) begin
            module_reset <= 1'h1;
        end else begin
            module_reset <= (next_state != eth_setup_pkg::RST_IDLE);
        end
    end

    // reset status: request sets it, clear bit clears it, set wins a tie
    always_ff @(posedge clk) begin
        if (srst) begin
            reset_status_flag <= 1'h0;
        end else if (wr_krst) begin
            reset_status_flag <= 1'h1;
        end else if (wr_kclr) begin
            reset_status_flag <= 1'h0;
        end
    end

    // mode select survives the soft reset; only a kernel reset or srst restores it
    always_ff @(posedge clk) begin
        if (srst || state == eth_setup_pkg::RST_KERNEL) begin
            interface_mode_select <= `RST_MODE_SEL;
        end else if (wr_mode) begin
            interface_mode_select <= reg_wdata[`BIT_MODE_SEL];
        end
    end

    // address words; low word write triggers the transfer of both
    always_ff @(posedge clk) begin
        if (srst || internal_clear) begin
            addr_high <= `RST_ADDR_HIGH;
            addr_low <= `RST_ADDR_LOW;
        end else begin
            if (wr_high) begin
                addr_high <= reg_wdata[15:0];
            end
            if (wr_low) begin
                addr_low <= reg_wdata;
            end
        end
    end

    // one cycle after the low write both words are stable for capture
    always_ff @(posedge clk) begin
        if (srst || internal_clear) begin
            sync.load <= 1'h0;
        end else begin
            sync.load <= wr_low;
        end
    end

    assign sync.clear = internal_clear;
    assign sync.high_word = addr_high;
    assign sync.low_word = addr_low;

    station_addr_sync u_addr_sync (
        .clk(clk),
        .srst(srst),
        .sync(sync)
    );

    // registered copy to keep the output straight from a flip-flop
    always_ff @(posedge clk) begin
        if (srst) begin
            station_address <= {`RST_ADDR_HIGH, `RST_ADDR_LOW};
        end else begin
            station_address <= sync.station_address;
        end
    end

    // halt is sticky until a reset of either kind; the DMA stays stopped
    always_ff @(posedge clk) begin
        if (srst || internal_clear) begin
            dma_halted <= 1'h0;
        end else if (desc_bad) begin
            dma_halted <= 1'h1;
        end
    end

    // fill state is unreliable for a while after any reset
    always_ff @(posedge clk) begin
        if (srst || internal_clear) begin
            settle_count <= SETTLE_W'(`FILL_SETTLE_CYCLES);
        end else if (settle_count != '0) begin
            settle_count <= settle_count - SETTLE_W'(1);
        end
    end

    assign fill_settled = (settle_count == '0);

    // fill state field hidden until settled, so early reads never show a stale nonzero
    always_comb begin
        rx_debug_view = rx_queue_debug;
        if (!fill_settled) begin
            rx_debug_view[`FILL_STATE_MSB:`FILL_STATE_LSB] = 2'h0;
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        next_rdata = 32'h00000000;
        unique case (reg_addr)
            `OFS_MODE_CTRL: next_rdata[`BIT_MODE_SEL] = interface_mode_select;
            `OFS_SOFT_RESET: next_rdata[`BIT_SOFT_RESET] = soft_reset_request;
            `OFS_KRST_REQ: next_rdata[`BIT_RST_STATUS] = reset_status_flag;
            `OFS_DMA_DEBUG: next_rdata[7:0] = {tx_process_state, rx_process_state};
            `OFS_RXQ_DEBUG: next_rdata = rx_debug_view;
            `OFS_TXQ_DEBUG: next_rdata = tx_queue_debug;
            `OFS_SETUP_STATUS: begin
                next_rdata[`BIT_FILL_SETTLED] = fill_settled;
                next_rdata[`BIT_DMA_HALTED] = dma_halted;
                next_rdata[`BIT_ADDR_BUSY] = sync.busy;
            end
            `OFS_ADDR_HIGH: next_rdata[15:0] = addr_high;
            `OFS_ADDR_LOW: next_rdata = addr_low;
            default: next_rdata = 32'h00000000;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_read) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

endmodule : eth_reset_setup

`default_nettype wire

// ===== dma_side_model.sv
// far side stand-in: dma process states, queue debug words, fetched descriptors
`timescale 1ns/1ps
`default_nettype none

module dma_side_model (
    // clock
    input wire logic clk,
    // commands from the bench
    input wire logic traffic,
    input wire logic fetch,
    input wire logic [31:0] fetch_word2,
    input wire logic [31:0] fetch_word3,
    // toward the block
    output logic [3:0] rx_process_state,
    output logic [3:0] tx_process_state,
    output logic [31:0] rx_queue_debug,
    output logic [31:0] tx_queue_debug,
    output logic desc_valid,
    output logic [31:0] tx_descriptor_word2,
    output logic [31:0] tx_descriptor_word3
);
    logic [31:0] filler = 32'h0;

    // processes report stopped and queues read zero only once traffic ends
    always_ff @(posedge clk) begin
        rx_process_state <= traffic ? 4'h3 : 4'h0;
        tx_process_state <= traffic ? 4'h6 : 4'h0;
        rx_queue_debug <= traffic ? 32'h31 : 32'h0;
        tx_queue_debug <= traffic ? 32'h12 : 32'h0;
    end

    // words only hold while valid; otherwise they flip so stale data never looks good
    always_ff @(posedge clk) begin
        filler <= ~filler;
        desc_valid <= fetch;
        tx_descriptor_word2 <= fetch ? fetch_word2 : filler;
        tx_descriptor_word3 <= fetch ? fetch_word3 : filler;
    end
endmodule : dma_side_model

`default_nettype wire

// ===== eth_reset_setup_properties.sv
// port assertions for the reset and address setup block
`timescale 1ns/1ps
`default_nettype none
`include "eth_setup_regs.svh"

module eth_reset_setup_chk (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    // privilege
    input wire logic supervisor_mode,
    input wire logic init_lock_active,
    // descriptors
    input wire logic desc_valid,
    input wire logic [31:0] tx_descriptor_word2,
    input wire logic [31:0] tx_descriptor_word3,
    // controls
    input wire logic module_reset,
    input wire logic interface_mode_select,
    input wire logic dma_halted,
    input wire logic [47:0] station_address
);
    logic wr_ok;
    logic bad_desc;
    logic [15:0] high_cap;
    logic [47:0] addr_exp;
    logic [3:0] quiet;

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    // writes only count while no module reset runs
    assign wr_ok = reg_write && !module_reset;
    assign bad_desc = desc_valid && tx_descriptor_word3[`BIT_LAST_SEGMENT]
        && (tx_descriptor_word2[13:0] == 14'h0 || tx_descriptor_word2[29:16] == 14'h0);

    // expected address rebuilt from software writes
    always_ff @(posedge clk) begin
        if (srst || module_reset) begin
            high_cap <= `RST_ADDR_HIGH;
        end else if (reg_write && reg_addr == `OFS_ADDR_HIGH) begin
            high_cap <= reg_wdata[15:0];
        end else if (reg_write && reg_addr == `OFS_ADDR_LOW) begin
            addr_exp <= {high_cap, reg_wdata};
        end
    end

    // cycles since the last address trigger or reset, saturating
    always_ff @(posedge clk) begin
        if (srst || module_reset || (reg_write && reg_addr == `OFS_ADDR_LOW)) begin
            quiet <= 4'h0;
        end else if (quiet != 4'hF) begin
            quiet <= quiet + 4'h1;
        end
    end

    property p_soft_pulse;
        wr_ok && reg_addr == `OFS_SOFT_RESET && reg_wdata[0] |=> module_reset[*3] ##1 !module_reset;
    endproperty
    a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset length wrong");
    property p_soft_mode;
        wr_ok && reg_addr == `OFS_SOFT_RESET && reg_wdata[0] |=> $stable(interface_mode_select)[*4];
    endproperty
    a_soft_mode: assert property (p_soft_mode) else $error("mode lost in soft reset");
    property p_krst_go;
        wr_ok && reg_addr == `OFS_KRST_REQ && reg_wdata[0] && supervisor_mode && !init_lock_active
            |=> module_reset[*3] ##1 !module_reset;
    endproperty
    a_krst_go: assert property (p_krst_go) else $error("kernel reset length wrong");
    property p_krst_refused;
        wr_ok && (reg_addr == `OFS_KRST_REQ || reg_addr == `OFS_KRST_CLR)
            && (!supervisor_mode || init_lock_active) |=> !module_reset;
    endproperty
    a_krst_refused: assert property (p_krst_refused) else $error("locked write acted");
    property p_halt_set;
        bad_desc && !module_reset && !reg_write |=> dma_halted;
    endproperty
    a_halt_set: assert property (p_halt_set) else $error("bad descriptor not halted");
    property p_halt_cause;
        $rose(dma_halted) |-> $past(bad_desc);
    endproperty
    a_halt_cause: assert property (p_halt_cause) else $error("halt without cause");
    property p_mode_write;
        wr_ok && reg_addr == `OFS_MODE_CTRL |=> interface_mode_select == $past(reg_wdata[0]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode write lost");
    property p_addr_load;
        wr_ok && reg_addr == `OFS_ADDR_LOW |=> ##[0:6] station_address == addr_exp;
    endproperty
    a_addr_load: assert property (p_addr_load) else $error("address not transferred");
    property p_addr_quiet;
        quiet >= 4'hA |-> $stable(station_address);
    endproperty
    a_addr_quiet: assert property (p_addr_quiet) else $error("address moved untriggered");
endmodule : eth_reset_setup_chk

bind eth_reset_setup eth_reset_setup_chk chk_u (.clk, .srst, .reg_addr, .reg_wdata, .reg_write,
    .supervisor_mode, .init_lock_active, .desc_valid, .tx_descriptor_word2,
    .tx_descriptor_word3, .module_reset, .interface_mode_select, .dma_halted,
    .station_address);

`default_nettype wire

// ===== tb.sv
// self-checking bench for the reset and address setup block
`timescale 1ns/1ps
`default_nettype none
`include "eth_setup_regs.svh"

module tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic supervisor_mode = 1'b0;
    logic init_lock_active = 1'b1;
    logic traffic = 1'b0;
    logic fetch = 1'b0;
    logic [31:0] fetch_word2 = 32'h0;
    logic [31:0] fetch_word3 = 32'h0;
    logic [3:0] rx_process_state, tx_process_state;
    logic [31:0] reg_rdata, rx_queue_debug, tx_queue_debug, tx_descriptor_word2, tx_descriptor_word3;
    logic desc_valid, module_reset, interface_mode_select, dma_halted;
    logic [47:0] station_address;
    int miscompares = 0;
    int check_count = 0;

    // 250 MHz
    always #2 clk = ~clk;

    dma_side_model side_u (.clk, .traffic, .fetch, .fetch_word2, .fetch_word3,
        .rx_process_state, .tx_process_state, .rx_queue_debug, .tx_queue_debug,
        .desc_valid, .tx_descriptor_word2, .tx_descriptor_word3);
    eth_reset_setup dut_u (.clk, .srst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .supervisor_mode, .init_lock_active, .rx_process_state,
        .tx_process_state, .rx_queue_debug, .tx_queue_debug, .desc_valid,
        .tx_descriptor_word2, .tx_descriptor_word3, .module_reset,
        .interface_mode_select, .dma_halted, .station_address);

    task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one-cycle write; returns on the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr

    // data only stand in the cycle after the strobe, so sample just past that edge
    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        chk(what, 48'(reg_rdata & m), 48'(e));
    endtask : rdc

    task automatic desc(input logic [31:0] w2, input logic [31:0] w3, input logic halt);
        @(posedge clk);
        fetch <= 1'b1;
        fetch_word2 <= w2;
        fetch_word3 <= w3;
        @(posedge clk);
        fetch <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("dma_halted", 48'(dma_halted), 48'(halt));
    endtask : desc

    task automatic t_reset_state();
        #1;
        chk("station_address", station_address, 48'hFFFF_FFFF_FFFF);
        traffic <= 1'b1;
        rdc("unsettled", `OFS_SETUP_STATUS, 32'h1, 32'h0);
        rdc("fill hidden", `OFS_RXQ_DEBUG, 32'hFFFF_FFFF, 32'h0000_0001);
        traffic <= 1'b0;
        rdc("unmapped", 8'h3C, 32'hFFFF_FFFF, 32'h0);
        repeat (80) @(posedge clk);
        rdc("settled", `OFS_SETUP_STATUS, 32'h1, 32'h1);
    endtask : t_reset_state

    task automatic t_queue();
        traffic <= 1'b1;
        rdc("txq busy", `OFS_TXQ_DEBUG, 32'hFFFF_FFFF, 32'h12);
        rdc("dma busy", `OFS_DMA_DEBUG, 32'hFF, 32'h63);
        rdc("fill shown", `OFS_RXQ_DEBUG, 32'hFFFF_FFFF, 32'h31);
        // read data must fall back to zero once the read cycle is over
        @(posedge clk);
        #1 chk("rdata drop", 48'(reg_rdata), 48'h0);
        traffic <= 1'b0;
        repeat (2) @(posedge clk);
        rdc("txq idle", `OFS_TXQ_DEBUG, 32'hFFFF_FFFF, 32'h0);
        rdc("rxq idle", `OFS_RXQ_DEBUG, 32'hFFFF_FFFF, 32'h0);
        rdc("dma idle", `OFS_DMA_DEBUG, 32'hFF, 32'h0);
    endtask : t_queue

    task automatic t_kernel();
        wr(`OFS_MODE_CTRL, 32'h1);
        supervisor_mode <= 1'b1;
        wr(`OFS_KRST_REQ, 32'h1);
        #1 chk("locked", 48'(module_reset), 48'h0);
        // privilege inputs change only on a rising edge
        @(posedge clk);
        init_lock_active <= 1'b0;
        supervisor_mode <= 1'b0;
        wr(`OFS_KRST_REQ, 32'h1);
        #1 chk("user mode", 48'(module_reset), 48'h0);
        @(posedge clk);
        supervisor_mode <= 1'b1;
        wr(`OFS_KRST_REQ, 32'h1);
        #1 chk("kernel reset", 48'(module_reset), 48'h1);
        repeat (5) @(posedge clk);
        #1 chk("kernel mode", 48'(interface_mode_select), 48'h0);
        rdc("flag set", `OFS_KRST_REQ, 32'h2, 32'h2);
        @(posedge clk);
        init_lock_active <= 1'b1;
        wr(`OFS_KRST_CLR, 32'h1);
        rdc("flag kept", `OFS_KRST_REQ, 32'h2, 32'h2);
        @(posedge clk);
        init_lock_active <= 1'b0;
        wr(`OFS_KRST_CLR, 32'h1);
        rdc("flag clear", `OFS_KRST_REQ, 32'h2, 32'h0);
        @(posedge clk);
        init_lock_active <= 1'b1;
    endtask : t_kernel

    task automatic t_soft();
        wr(`OFS_MODE_CTRL, 32'h1);
        desc(32'h0001_0001, 32'h1000_0000, 1'b0);
        desc(32'h0, 32'h0, 1'b0);
        desc(32'h0001_0000, 32'h1000_0000, 1'b1);
        rdc("halt flag", `OFS_SETUP_STATUS, 32'h2, 32'h2);
        wr(`OFS_SOFT_RESET, 32'h1);
        #1 chk("soft start", 48'(module_reset), 48'h1);
        rdc("soft busy", `OFS_SOFT_RESET, 32'h1, 32'h1);
        repeat (4) @(posedge clk);
        rdc("soft bit", `OFS_SOFT_RESET, 32'h1, 32'h0);
        chk("soft done", 48'(module_reset), 48'h0);
        chk("halt cleared", 48'(dma_halted), 48'h0);
        chk("mode kept", 48'(interface_mode_select), 48'h1);
        desc(32'h0000_0001, 32'h1000_0000, 1'b1);
    endtask : t_soft

    task automatic t_addr();
        wr(`OFS_ADDR_HIGH, 32'h0000_1A2B);
        repeat (8) @(posedge clk);
        chk("high alone", station_address, 48'hFFFF_FFFF_FFFF);
        wr(`OFS_ADDR_LOW, 32'h3C4D_5E6F);
        rdc("addr busy", `OFS_SETUP_STATUS, 32'h4, 32'h4);
        repeat (8) @(posedge clk);
        chk("address", station_address, 48'h1A2B_3C4D_5E6F);
        wr(`OFS_ADDR_LOW, 32'h0102_0304);
        repeat (8) @(posedge clk);
        chk("low again", station_address, 48'h1A2B_0102_0304);
        rdc("low readback", `OFS_ADDR_LOW, 32'hFFFF_FFFF, 32'h0102_0304);
    endtask : t_addr

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        t_reset_state();
        t_queue();
        t_kernel();
        t_soft();
        t_addr();
        test_done();
    end

    // the run needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk);
        miscompares++;
        test_done();
    end
endmodule : tb

`default_nettype wire
